// ---- bench/cpu_state_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpu_state_regs.vh"
module cpu_state_monitor #(
  parameter logic [15:0] LAST_SRAM_ADDR = `LAST_SRAM_ADDRESS
) (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic        ds_wr,
  input wire logic [5:0]  io_addr,
  input wire logic [2:0]  sp_op,
  input wire logic        irq_taken,
  input wire logic        return_from_irq_instr,
  input wire logic        set_irq_instr,
  input wire logic        clear_irq_instr,
  input wire logic        alu_op,
  input wire logic [7:0]  alu_flag_mask,
  input wire logic [7:0]  cpu_flags_r,
  input wire logic [15:0] stack_ptr,
  input wire logic        irq_req_r,
  input wire logic [7:0]  io_rdata_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Explicit writes outrank every other update, so they are left out
  wire quiet = !io_wr && !ds_wr;
  wire sp_free = quiet && !irq_taken && !return_from_irq_instr;
  property p_reset_sp; $rose(rstn) |-> stack_ptr == LAST_SRAM_ADDR;
  endproperty
  a_reset_sp: assert property (p_reset_sp) else $error("stack pointer reset value wrong");
  property p_push; sp_free && sp_op == `SP_OP_PUSH |=> stack_ptr == $past(stack_ptr) - 16'h0001;
  endproperty
  a_push: assert property (p_push) else $error("push step wrong");
  property p_entry_sp; quiet && irq_taken |=> stack_ptr == $past(stack_ptr) - 16'h0002;
  endproperty
  a_entry_sp: assert property (p_entry_sp) else $error("interrupt entry step wrong");
  property p_iret_sp;
    quiet && !irq_taken && return_from_irq_instr |=> stack_ptr == $past(stack_ptr) + 16'h0002;
  endproperty
  a_iret_sp: assert property (p_iret_sp) else $error("interrupt return step wrong");
  property p_gate_clr; quiet && irq_taken |=> !cpu_flags_r[7];
  endproperty
  a_gate_clr: assert property (p_gate_clr) else $error("gate kept on entry");
  property p_gate_set;
    quiet && !irq_taken && (return_from_irq_instr || set_irq_instr && !clear_irq_instr)
      |=> cpu_flags_r[7];
  endproperty
  a_gate_set: assert property (p_gate_set) else $error("gate not set");
  property p_cli;
    quiet && !irq_taken && !return_from_irq_instr && clear_irq_instr
      |-> ##1 !cpu_flags_r[7] && !irq_req_r;
  endproperty
  a_cli: assert property (p_cli) else $error("clear gate did not block");
  property p_sign; quiet && alu_op && |alu_flag_mask[3:2] |=> cpu_flags_r[4] == ^cpu_flags_r[3:2];
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag not n xor v");
  property p_mask; irq_req_r && !$past(io_wr) && !$past(ds_wr) |-> cpu_flags_r[7];
  endproperty
  a_mask: assert property (p_mask) else $error("request with gate closed");
  property p_holdoff; return_from_irq_instr |=> !irq_req_r;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("request right after return");
  property p_io_sp;
    io_rd && sp_free && io_addr == `IO_STACK_PTR_HIGH && sp_op == `SP_OP_NONE
      |=> io_rdata_r == stack_ptr[15:8];
  endproperty
  a_io_sp: assert property (p_io_sp) else $error("stack high byte read wrong");
endmodule
bind cpu_status_stack_regfile cpu_state_monitor #(.LAST_SRAM_ADDR(LAST_SRAM_ADDR)) mon (
  .clk_sys, .rstn, .io_wr, .io_rd, .ds_wr, .io_addr, .sp_op, .irq_taken,
  .return_from_irq_instr, .set_irq_instr, .clear_irq_instr, .alu_op, .alu_flag_mask,
  .cpu_flags_r, .stack_ptr, .irq_req_r, .io_rdata_r);
`default_nettype wire

// ---- bench/cpu_status_stack_regfile_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpu_state_regs.vh"
module cpu_status_stack_regfile_test;
  localparam logic [15:0] LAST = 16'h08FF;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        res_wr, res_wide, alu_op, set_irq_instr, clear_irq_instr, return_from_irq_instr;
  logic        irq_taken, bit_store_instr, bit_load_instr, instr_done, irq_pending, io_wr;
  logic        io_rd, ds_wr, ds_rd, ptr_req, jump_en, fetch_en;
  logic [4:0]  op_a_idx, op_b_idx, res_idx;
  logic [15:0] res_data, ds_addr, jump_addr, sp, p, w;
  logic [7:0]  alu_flag_mask, alu_flags, io_wdata, ds_wdata, fl, m;
  logic [5:0]  io_addr, ptr_disp;
  logic [2:0]  bit_sel, sp_op;
  logic [1:0]  ptr_sel, ptr_mode;
  wire         fetch_valid, irq_req_r, ds_hit_r, ptr_valid_r;
  wire  [7:0]  op_a_r, op_b_r, io_rdata_r, ds_rdata_r, cpu_flags_r;
  wire  [15:0] fetch_word, op_wide_r, ptr_addr_r, fetch_addr_r, exec_instr_r, stack_ptr;
  logic [31:0] seed = 32'h4FEAC0BC;
  logic [7:0]  gpr [32];
  logic [15:0] fq [$];
  int          fail_count = 0;
  int          samples_checked = 0;
  int          k;

  cpu_status_stack_regfile #(.LAST_SRAM_ADDR(LAST)) dut (.*);
  prog_store_model far (.*);

  always #4 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic zero();
    {res_wr, res_wide, alu_op, set_irq_instr, clear_irq_instr, return_from_irq_instr, irq_taken,
     bit_store_instr, bit_load_instr, instr_done, io_wr, io_rd, ds_wr, ds_rd, ptr_req, jump_en} = '0;
    sp_op = `SP_OP_NONE;
  endtask
  task automatic cyc();
    @(negedge clk_sys);
    zero();
  endtask
  task automatic fchk();
    cyc();
    chk(cpu_flags_r, fl);
  endtask
  task automatic iow(input logic [5:0] a, input logic [7:0] d);
    cyc();
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
  endtask
  task automatic ior(input logic [5:0] a, input logic [7:0] e);
    cyc();
    io_rd = 1'b1;
    io_addr = a;
    cyc();
    chk(io_rdata_r, e);
  endtask
  task automatic dsr(input logic [15:0] a, input logic [7:0] e, input logic h);
    cyc();
    ds_rd = 1'b1;
    ds_addr = a;
    cyc();
    chk(ds_rdata_r, e);
    chk(ds_hit_r, h);
  endtask
  task automatic rd(input logic [4:0] i);
    cyc();
    op_a_idx = i;
    op_b_idx = ~i;
    cyc();
    chk(op_a_r, gpr[i]);
    chk(op_b_r, gpr[~i]);
    chk(op_wide_r, {gpr[i | 5'd1], gpr[i & 5'd30]});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  initial begin
    zero();
    {op_a_idx, op_b_idx, res_idx, res_data, ds_addr, jump_addr, alu_flag_mask, alu_flags, io_wdata,
     ds_wdata, io_addr, ptr_disp, bit_sel, ptr_sel, ptr_mode, irq_pending, fetch_en} = '0;
    sp = LAST;
    fl = 8'h00;
    foreach (gpr[i]) gpr[i] = 8'h00;
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    chk(stack_ptr, sp);
    chk(cpu_flags_r, fl);
    for (int i = 0; i < 40; i++) begin
      cyc();
      k = rnd() % 5;
      sp_op = k[2:0];
      sp = sp - (k == 1) - 2 * (k == 2) + (k == 3) + 2 * (k == 4);
      cyc();
      chk(stack_ptr, sp);
    end
    w = rnd();
    iow(`IO_STACK_PTR_LOW, w[7:0]);
    iow(`IO_STACK_PTR_HIGH, w[15:8]);
    sp = w;
    ior(`IO_STACK_PTR_LOW, sp[7:0]);
    ior(`IO_STACK_PTR_HIGH, sp[15:8]);
    ior(6'h10, 8'h00);
    for (int i = 0; i < 32; i++) begin
      cyc();
      w = rnd();
      gpr[i] = w[7:0];
      if (i % 2) begin
        ds_wr = 1'b1;
        ds_addr = i[15:0];
        ds_wdata = w[7:0];
      end else begin
        res_wr = 1'b1;
        res_idx = i[4:0];
        res_data = w;
      end
    end
    for (int i = 0; i < 32; i++) rd(i[4:0]);
    for (int i = 0; i < 32; i += 7) dsr(i[15:0], gpr[i], 1'b1);
    dsr(16'h005D, sp[7:0], 1'b1);
    cyc();
    ds_wr = 1'b1;
    ds_addr = 16'h005E;
    ds_wdata = ~sp[15:8];
    sp[15:8] = ~sp[15:8];
    ior(`IO_STACK_PTR_HIGH, sp[15:8]);
    dsr(16'h0100, 8'h00, 1'b0);
    cyc();
    res_wr = 1'b1;
    res_wide = 1'b1;
    res_idx = 5'd25;
    res_data = 16'h0123;
    {gpr[25], gpr[24]} = 16'h0123;
    rd(5'd24);
    for (int i = 0; i < 3; i++) begin
      k = 26 + 2 * i;
      p = {gpr[k + 1], gpr[k]};
      cyc();
      ptr_req = 1'b1;
      ptr_sel = i[1:0];
      ptr_mode = i[1:0];
      w = rnd();
      ptr_disp = w[5:0];
      w = i == 0 ? p + w[5:0] : i == 1 ? p : p - 16'h0001;
      p = i == 1 ? p + 16'h0001 : i == 2 ? p - 16'h0001 : p;
      {gpr[k + 1], gpr[k]} = p;
      cyc();
      chk(ptr_addr_r, w);
      chk(ptr_valid_r, 1'b1);
      rd(k[4:0]);
    end
    for (int i = 0; i < 30; i++) begin
      cyc();
      alu_op = 1'b1;
      w = rnd();
      alu_flag_mask = w[7:0];
      alu_flags = w[15:8];
      m = w[7:0] & `FLAG_ALU_MASK;
      fl = (fl & ~m) | (w[15:8] & m);
      if (w[2] | w[3]) fl[4] = fl[2] ^ fl[3];
      fchk();
    end
    cyc();
    alu_op = 1'b1;
    alu_flag_mask = 8'hFF;
    alu_flags = 8'hFF;
    io_wr = 1'b1;
    io_addr = `IO_CPU_FLAGS;
    io_wdata = 8'h52;
    fl = 8'h52;
    fchk();
    irq_pending = 1'b1;
    set_irq_instr = 1'b1;
    fl[7] = 1'b1;
    fchk();
    instr_done = 1'b1;
    cyc();
    cyc();
    chk(irq_req_r, 1'b1);
    clear_irq_instr = 1'b1;
    fl[7] = 1'b0;
    fchk();
    chk(irq_req_r, 1'b0);
    set_irq_instr = 1'b1;
    cyc();
    irq_taken = 1'b1;
    sp = sp - 16'h0002;
    fchk();
    chk(stack_ptr, sp);
    return_from_irq_instr = 1'b1;
    fl[7] = 1'b1;
    sp = sp + 16'h0002;
    fchk();
    chk(stack_ptr, sp);
    chk(irq_req_r, 1'b0);
    instr_done = 1'b1;
    cyc();
    cyc();
    chk(irq_req_r, 1'b1);
    for (int b = 0; b < 8; b++) begin
      cyc();
      op_a_idx = 5'd4;
      bit_store_instr = 1'b1;
      bit_sel = b[2:0];
      fl[6] = gpr[4][b];
      fchk();
      op_a_idx = 5'd9;
      bit_load_instr = 1'b1;
      bit_sel = b[2:0];
      gpr[9][b] = fl[6];
    end
    rd(5'd9);
    cyc();
    jump_en = 1'b1;
    jump_addr = 16'h0040;
    w = 16'h0040;
    cyc();
    chk(fetch_addr_r, w);
    for (int i = 0; i < 3; i++) begin
      fq.push_back(w ^ 16'hA5C3);
      fetch_en = 1'b1;
      cyc();
      fetch_en = 1'b0;
      cyc();
      w = w + 16'h0001;
      chk(fetch_addr_r, w);
      repeat (rnd() % 3) cyc();
      instr_done = 1'b1;
      cyc();
      chk(exec_instr_r, fq.pop_front());
    end
    close_out();
  end
endmodule
`default_nettype wire

// ---- bench/prog_store_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module prog_store_model (
  input  wire logic        clk_sys,
  input  wire logic        fetch_en,
  input  wire logic [15:0] fetch_addr_r,
  output var  logic        fetch_valid,
  output var  logic [15:0] fetch_word
);
  initial fetch_valid = 1'b0;
  initial fetch_word = 16'h0000;
  // Idle word keeps toggling so a stale value can never pass as fetched
  always @(posedge clk_sys) begin
    fetch_valid <= fetch_en;
    fetch_word  <= fetch_en ? (fetch_addr_r ^ 16'hA5C3) : ~fetch_word;
  end
endmodule
`default_nettype wire

// ---- design/cpu_status_stack_regfile.v ----
`timescale 1ns/1ps
`default_nettype none
`include "cpu_state_regs.vh"

// Operation
// - ALU flag results update the masked flags on every ALU operation unless the flags register is written in that cycle.
// - Interrupt entry and return never save or restore the flags.
// - Interrupt gate bit 7 at zero masks every interrupt request.
// - Taking an interrupt clears the gate; interrupt return sets it.
// - Set-interrupt sets the gate; clear-interrupt clears it.
// - Bit 6 holds a bit copied from or into a working register.
// - Bit 5 records low-nibble carry of affecting arithmetic.
// - Bit 4 equals negative XOR overflow, recomputed when an ALU operation's mask covers either.
// - Bit 3 records signed overflow of the last affecting result.
// - Bit 2 records a negative result of the last affecting operation.
// - Bit 1 records an all-zero result of the last affecting operation.
// - Bit 0 records carry or borrow of the last affecting operation.
// - Register file offers 8/16-bit read and write port combinations.
// - Working registers answer data-space addresses 0 to 31.
// - Registers 26 to 31 form three 16-bit pointers.
// - Pointers support displacement, post-increment and pre-decrement.
// - Stack grows downward; pointer addresses the stack top.
// - Push/pop step by one; calls, interrupts and returns by two.
// - Reset loads stack pointer with the last SRAM address.
// - Stack pointer is two read/write I/O bytes at 0x3E and 0x3D.
// - Read two operands, compute and write back in one cycle.
// - Fetch of the next instruction overlaps current execution.
// - Next instruction is prefetched while one executes.
// - After interrupt return one instruction runs before any interrupt.
module cpu_status_stack_regfile #(
  parameter [15:0] LAST_SRAM_ADDR = `LAST_SRAM_ADDRESS,
  parameter        PC_WIDTH       = 16,
  parameter        INSTR_WIDTH    = 16
) (
  input  wire                   clk_sys,
  input  wire                   rstn,
  // Operand and result ports
  input  wire [4:0]             op_a_idx,
  input  wire [4:0]             op_b_idx,
  output reg  [7:0]             op_a_r,
  output reg  [7:0]             op_b_r,
  output reg  [15:0]            op_wide_r,
  input  wire                   res_wr,
  input  wire                   res_wide,
  input  wire [4:0]             res_idx,
  input  wire [15:0]            res_data,
  // ALU flag results
  input  wire                   alu_op,
  input  wire [7:0]             alu_flag_mask,
  input  wire [7:0]             alu_flags,
  // Instruction strobes
  input  wire                   set_irq_instr,
  input  wire                   clear_irq_instr,
  input  wire                   return_from_irq_instr,
  input  wire                   irq_taken,
  input  wire                   bit_store_instr,
  input  wire                   bit_load_instr,
  input  wire [2:0]             bit_sel,
  input  wire [2:0]             sp_op,
  input  wire                   instr_done,
  // Interrupt gating
  input  wire                   irq_pending,
  output reg                    irq_req_r,
  // I/O space
  input  wire [5:0]             io_addr,
  input  wire                   io_wr,
  input  wire                   io_rd,
  input  wire [7:0]             io_wdata,
  output reg  [7:0]             io_rdata_r,
  // Data space
  input  wire [15:0]            ds_addr,
  input  wire                   ds_wr,
  input  wire                   ds_rd,
  input  wire [7:0]             ds_wdata,
  output reg  [7:0]             ds_rdata_r,
  output reg                    ds_hit_r,
  // Pointer addressing
  input  wire                   ptr_req,
  input  wire [1:0]             ptr_sel,
  input  wire [1:0]             ptr_mode,
  input  wire [5:0]             ptr_disp,
  output reg  [15:0]            ptr_addr_r,
  output reg                    ptr_valid_r,
  // Fetch pipeline
  input  wire                   fetch_valid,
  input  wire [INSTR_WIDTH-1:0] fetch_word,
  input  wire                   jump_en,
  input  wire [PC_WIDTH-1:0]    jump_addr,
  output reg  [PC_WIDTH-1:0]    fetch_addr_r,
  output reg  [INSTR_WIDTH-1:0] exec_instr_r,
  // State views
  output reg  [7:0]             cpu_flags_r,
  output wire [15:0]            stack_ptr
);

  reg  [7:0]             flags_nxt;
  reg                    block_r;
  reg                    block_nxt;
  reg  [INSTR_WIDTH-1:0] next_instr_r;
  reg                    wr_en;
  reg                    wr_wide;
  reg  [4:0]             wr_idx;
  reg  [15:0]            wr_data;
  reg  [7:0]             load_val;
  reg  [15:0]            ptr_eff;
  reg  [15:0]            ptr_wb;
  reg  [2:0]             sp_op_eff;

  wire [7:0]  rd_a;
  wire [7:0]  rd_b;
  wire [7:0]  rd_c;
  wire [15:0] rd_wide;
  wire [15:0] pair_val;
  wire [15:0] ds_io_off = ds_addr - `DS_IO_BASE;
  wire        ds_in_gpr = (ds_addr <= `DS_GPR_END);
  wire        ds_in_io  = (ds_addr >= `DS_IO_BASE) && (ds_addr <= `DS_IO_END);
  wire [5:0]  ds_io_idx = ds_io_off[5:0];
  wire        ds_io_wr  = ds_wr && ds_in_io;
  wire [5:0]  wr_io_idx = io_wr ? io_addr : ds_io_idx;
  wire        any_io_wr = io_wr || ds_io_wr;
  wire        flags_wr  = any_io_wr && (wr_io_idx == `IO_CPU_FLAGS);
  wire        sp_wr_lo  = any_io_wr && (wr_io_idx == `IO_STACK_PTR_LOW);
  wire        sp_wr_hi  = any_io_wr && (wr_io_idx == `IO_STACK_PTR_HIGH);
  wire [7:0]  io_wval   = io_wr ? io_wdata : ds_wdata;
  wire [4:0]  pair_idx  = ptr_base(ptr_sel);
  wire        ptr_wb_en = ptr_req && (ptr_mode != `PTR_MODE_DISP);

  function [4:0] ptr_base;
    input [1:0] sel;
    begin
      ptr_base = `PTR_BASE_REG + {2'b00, sel, 1'b0};
    end
  endfunction

  function [7:0] io_read;
    input [5:0]  idx;
    input [7:0]  flags;
    input [15:0] sp;
    begin
      if (idx == `IO_STACK_PTR_LOW) begin
        io_read = sp[7:0];
      end else if (idx == `IO_STACK_PTR_HIGH) begin
        io_read = sp[15:8];
      end else if (idx == `IO_CPU_FLAGS) begin
        io_read = flags;
      end else begin
        io_read = 8'h00;
      end
    end
  endfunction

  // Flags next value; later assignments take precedence
  always @* begin
    flags_nxt = cpu_flags_r;
    if (alu_op) begin
      // H, V, N, Z and C straight from the ALU, per-flag mask
      flags_nxt = (cpu_flags_r & ~(alu_flag_mask & `FLAG_ALU_MASK)) |
                  (alu_flags & alu_flag_mask & `FLAG_ALU_MASK);
      if (alu_flag_mask[`FLAG_NEGATIVE] || alu_flag_mask[`FLAG_OVERFLOW]) begin
        flags_nxt[`FLAG_SIGN] = flags_nxt[`FLAG_NEGATIVE] ^ flags_nxt[`FLAG_OVERFLOW];
      end
    end
    if (bit_store_instr) begin
      flags_nxt[`FLAG_BIT_STORE] = rd_a[bit_sel];
    end
    if (set_irq_instr) begin
      flags_nxt[`FLAG_IRQ_GATE] = 1'b1;
    end
    if (clear_irq_instr) begin
      flags_nxt[`FLAG_IRQ_GATE] = 1'b0;
    end
    if (return_from_irq_instr) begin
      flags_nxt[`FLAG_IRQ_GATE] = 1'b1;
    end
    // Only the gate moves on entry; other flags are software's to save
    if (irq_taken) begin
      flags_nxt[`FLAG_IRQ_GATE] = 1'b0;
    end
    if (flags_wr) begin
      flags_nxt = io_wval;
    end
  end

  // Interrupt holdoff for one instruction after return or set-interrupt
  always @* begin
    block_nxt = block_r;
    if (instr_done) begin
      block_nxt = 1'b0;
    end
    if (return_from_irq_instr || set_irq_instr) begin
      block_nxt = 1'b1;
    end
  end

  // Write port arbitration: data-space store, then bit-load, then ALU result
  always @* begin
    load_val          = rd_a;
    load_val[bit_sel] = cpu_flags_r[`FLAG_BIT_STORE];
    wr_en             = 1'b0;
    wr_wide           = 1'b0;
    wr_idx            = res_idx;
    wr_data           = res_data;
    if (ds_wr && ds_in_gpr) begin
      wr_en   = 1'b1;
      wr_idx  = ds_addr[4:0];
      wr_data = {8'h00, ds_wdata};
    end else if (bit_load_instr) begin
      wr_en   = 1'b1;
      wr_idx  = op_a_idx;
      wr_data = {8'h00, load_val};
    end else if (res_wr) begin
      wr_en   = 1'b1;
      wr_wide = res_wide;
    end
  end

  // Pointer effective address and write-back value
  always @* begin
    ptr_eff = pair_val;
    ptr_wb  = pair_val;
    case (ptr_mode)
      `PTR_MODE_DISP: begin
        ptr_eff = pair_val + {10'h000, ptr_disp};
      end
      `PTR_MODE_POSTINC: begin
        ptr_wb = pair_val + 16'h0001;
      end
      `PTR_MODE_PREDEC: begin
        ptr_eff = pair_val - 16'h0001;
        ptr_wb  = pair_val - 16'h0001;
      end
      default: begin
        ptr_eff = pair_val;
      end
    endcase
  end

  // Interrupt entry and returns move the stack by a full address
  always @* begin
    sp_op_eff = sp_op;
    if (irq_taken) begin
      sp_op_eff = `SP_OP_CALL;
    end else if (return_from_irq_instr) begin
      sp_op_eff = `SP_OP_RETURN;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpu_flags_r  <= `CPU_FLAGS_RESET;
      block_r      <= 1'b0;
      irq_req_r    <= 1'b0;
      op_a_r       <= 8'h00;
      op_b_r       <= 8'h00;
      op_wide_r    <= 16'h0000;
      io_rdata_r   <= 8'h00;
      ds_rdata_r   <= 8'h00;
      ds_hit_r     <= 1'b0;
      ptr_addr_r   <= 16'h0000;
      ptr_valid_r  <= 1'b0;
      fetch_addr_r <= {PC_WIDTH{1'b0}};
      next_instr_r <= {INSTR_WIDTH{1'b0}};
      exec_instr_r <= {INSTR_WIDTH{1'b0}};
    end else begin
      cpu_flags_r <= flags_nxt;
      block_r     <= block_nxt;
      // Uses next gate so a clear-interrupt blocks at once
      irq_req_r   <= flags_nxt[`FLAG_IRQ_GATE] && irq_pending &&
                     !block_nxt && !irq_taken;
      op_a_r      <= rd_a;
      op_b_r      <= rd_b;
      op_wide_r   <= rd_wide;
      if (io_rd) begin
        io_rdata_r <= io_read(io_addr, cpu_flags_r, stack_ptr);
      end
      ds_hit_r <= ds_rd && (ds_in_gpr || ds_in_io);
      if (ds_rd) begin
        if (ds_in_gpr) begin
          ds_rdata_r <= rd_c;
        end else if (ds_in_io) begin
          ds_rdata_r <= io_read(ds_io_idx, cpu_flags_r, stack_ptr);
        end else begin
          ds_rdata_r <= 8'h00;
        end
      end
      ptr_valid_r <= ptr_req;
      if (ptr_req) begin
        ptr_addr_r <= ptr_eff;
      end
      if (jump_en) begin
        fetch_addr_r <= jump_addr;
      end else if (fetch_valid) begin
        fetch_addr_r <= fetch_addr_r + {{(PC_WIDTH-1){1'b0}}, 1'b1};
      end
      if (fetch_valid) begin
        next_instr_r <= fetch_word;
      end
      if (instr_done) begin
        exec_instr_r <= next_instr_r;
      end
    end
  end

  gpr_bank #(
    .COUNT        (32)
  ) u_gpr (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .rd_a_idx     (op_a_idx),
    .rd_b_idx     (op_b_idx),
    .rd_c_idx     (ds_addr[4:0]),
    .pair_idx     (pair_idx),
    .rd_a         (rd_a),
    .rd_b         (rd_b),
    .rd_c         (rd_c),
    .rd_wide      (rd_wide),
    .pair_val     (pair_val),
    .wr_en        (wr_en),
    .wr_wide      (wr_wide),
    .wr_idx       (wr_idx),
    .wr_data      (wr_data),
    .pair_wr_en   (ptr_wb_en),
    .pair_wr_data (ptr_wb)
  );

  stack_ptr_unit #(
    .RESET_VALUE  (LAST_SRAM_ADDR)
  ) u_sp (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .sp_op        (sp_op_eff),
    .wr_low       (sp_wr_lo),
    .wr_high      (sp_wr_hi),
    .wdata        (io_wval),
    .sp_r         (stack_ptr)
  );

endmodule
`default_nettype wire

// ---- design/gpr_bank.v ----
`timescale 1ns/1ps
`default_nettype none
`include "cpu_state_regs.vh"

module gpr_bank #(
  parameter COUNT = 32
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire [4:0]  rd_a_idx,
  input  wire [4:0]  rd_b_idx,
  input  wire [4:0]  rd_c_idx,
  input  wire [4:0]  pair_idx,
  output wire [7:0]  rd_a,
  output wire [7:0]  rd_b,
  output wire [7:0]  rd_c,
  output wire [15:0] rd_wide,
  output wire [15:0] pair_val,
  input  wire        wr_en,
  input  wire        wr_wide,
  input  wire [4:0]  wr_idx,
  input  wire [15:0] wr_data,
  input  wire        pair_wr_en,
  input  wire [15:0] pair_wr_data
);

  reg [7:0] mem [0:COUNT-1];
  integer   i;

  // Combinational reads so operands, ALU and write-back fit one cycle
  assign rd_a     = mem[rd_a_idx];
  assign rd_b     = mem[rd_b_idx];
  assign rd_c     = mem[rd_c_idx];
  assign rd_wide  = {mem[{rd_a_idx[4:1], 1'b1}], mem[{rd_a_idx[4:1], 1'b0}]};
  assign pair_val = {mem[{pair_idx[4:1], 1'b1}], mem[{pair_idx[4:1], 1'b0}]};

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < COUNT; i = i + 1) begin
        mem[i] <= `GPR_RESET;
      end
    end else begin
      // Pointer write-back first so a result write to the same byte wins
      if (pair_wr_en) begin
        mem[{pair_idx[4:1], 1'b0}] <= pair_wr_data[7:0];
        mem[{pair_idx[4:1], 1'b1}] <= pair_wr_data[15:8];
      end
      if (wr_en) begin
        if (wr_wide) begin
          mem[{wr_idx[4:1], 1'b0}] <= wr_data[7:0];
          mem[{wr_idx[4:1], 1'b1}] <= wr_data[15:8];
        end else begin
          mem[wr_idx] <= wr_data[7:0];
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- design/stack_ptr_unit.v ----
`timescale 1ns/1ps
`default_nettype none
`include "cpu_state_regs.vh"

module stack_ptr_unit #(
  parameter [15:0] RESET_VALUE = `LAST_SRAM_ADDRESS
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire [2:0]  sp_op,
  input  wire        wr_low,
  input  wire        wr_high,
  input  wire [7:0]  wdata,
  output reg  [15:0] sp_r
);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sp_r <= RESET_VALUE;
    end else if (wr_low || wr_high) begin
      // Software write wins over a stack operation in the same cycle
      if (wr_low) begin
        sp_r[7:0] <= wdata;
      end
      if (wr_high) begin
        sp_r[15:8] <= wdata;
      end
    end else begin
      // Downward growth: pushes lower, pops raise
      case (sp_op)
        `SP_OP_PUSH: sp_r <= sp_r - `SP_STEP_BYTE;
        `SP_OP_CALL: sp_r <= sp_r - `SP_STEP_ADDR;
        `SP_OP_POP:  sp_r <= sp_r + `SP_STEP_BYTE;
        `SP_OP_RETURN: sp_r <= sp_r + `SP_STEP_ADDR;
        default:     sp_r <= sp_r;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- inc/cpu_state_regs.vh ----
`ifndef CPU_STATE_REGS_VH
`define CPU_STATE_REGS_VH

// I/O space offsets
`define IO_STACK_PTR_LOW   6'h3D
`define IO_STACK_PTR_HIGH  6'h3E
`define IO_CPU_FLAGS       6'h3F

// Data space windows
`define DS_GPR_END         16'h001F
`define DS_IO_BASE         16'h0020
`define DS_IO_END          16'h005F

// Flag bit positions
`define FLAG_IRQ_GATE      3'd7
`define FLAG_BIT_STORE     3'd6
`define FLAG_HALF_CARRY    3'd5
`define FLAG_SIGN          3'd4
`define FLAG_OVERFLOW      3'd3
`define FLAG_NEGATIVE      3'd2
`define FLAG_ZERO          3'd1
`define FLAG_CARRY         3'd0

// Flags that the ALU may update directly
`define FLAG_ALU_MASK      8'h2F
`define CPU_FLAGS_RESET    8'h00

// Reset values
`define LAST_SRAM_ADDRESS  16'h01FF
`define GPR_RESET          8'h00

// Pointer pairs
`define PTR_BASE_REG       5'd26
`define PTR_MODE_DISP      2'h0
`define PTR_MODE_POSTINC   2'h1
`define PTR_MODE_PREDEC    2'h2

// Stack pointer operations
`define SP_OP_NONE         3'h0
`define SP_OP_PUSH         3'h1
`define SP_OP_CALL         3'h2
`define SP_OP_POP          3'h3
`define SP_OP_RETURN       3'h4
`define SP_STEP_BYTE       16'h0001
`define SP_STEP_ADDR       16'h0002

`endif
